// [src/bwa_params.svh]
/*
  Constants of the binary word arithmetic and logic unit: widths,
  register offsets, field positions and reset values.
  Assumes inclusion by bare name from the package and the unit.
*/
`ifndef BWA_PARAMS_SVH
`define BWA_PARAMS_SVH

// Datapath and register port widths
`define BWA_W            16
`define BWA_AW           4

// Register offsets (word addresses on the plain port)
`define BWA_ADDR_CTRL    4'h0
`define BWA_ADDR_FLAGS   4'h1
`define BWA_ADDR_RES_LO  4'h2
`define BWA_ADDR_RES_HI  4'h3

// Field positions
`define BWA_CTRL_EN_BIT  0
`define BWA_FLG_CY_BIT   0
`define BWA_FLG_ZR_BIT   1
`define BWA_FLG_FT_BIT   2

// Reset values and fixed words
`define BWA_CTRL_RST     1'b1
`define BWA_WORD_ZERO    16'h0000
`define BWA_DWORD_ZERO   32'h0000_0000

// Controller bit address at which the carry flag is held
`define BWA_CARRY_BIT_ADDR 25504

`endif

// [src/bwa_pkg.sv]
/*
  Types of the binary word arithmetic and logic unit: operation codes,
  the request carried from the sequencer and the flag group.
  Assumes bwa_params.svh is on the include path.
*/
`include "bwa_params.svh"

package bwa_pkg;

  // Operation codes, one-hot
  typedef enum logic [4:0] {
    bwa_binary_subtract_op     = 5'h01,
    bwa_binary_multiply_op     = 5'h02,
    bwa_binary_divide_op       = 5'h04,
    bwa_bitwise_conjunction_op = 5'h08,
    bwa_carry_clear_op         = 5'h10
  } bwa_op_t;

  // One instruction as handed over by the sequencer
  typedef struct packed {
    bwa_op_t             op;
    logic                exec_cond;
    logic                operand_fault;
    logic [`BWA_W-1:0]   operand_a;
    logic [`BWA_W-1:0]   operand_b;
  } bwa_req_t;

  // Controller flags
  typedef struct packed {
    logic fault_indicator;
    logic zero_result_flag;
    logic carry_flag;
  } bwa_flags_t;

endpackage

// [src/bwa_alu.sv]
/*
  Binary word arithmetic and logic unit: subtract with borrow, multiply
  to two words, divide to quotient and remainder, bitwise AND and carry
  clear on 16-bit unsigned words, with carry, zero and fault flags and
  a small register port.
  Assumes the sequencer presents one instruction per op_valid cycle,
  with operands already fetched and operand_fault set when an
  indirectly addressed word does not exist.
*/
// Functional notes
// - With execution condition false, results and flags stay untouched.
// - Subtract: base word minus deducted word minus carry, low word out.
// - Negative difference sets carry, result is two's complement.
// - Carry after subtract is one exactly when base < deducted+carry.
// - Multiply: product low word to result, high word to next word.
// - Divide numerator by denominator; zero denominator raises fault.
// - Divide writes quotient to first word, remainder to next word.
// - Bitwise AND of the two logic inputs goes to the result.
// - Zero flag set when the produced result is zero (both product words for multiply), else cleared.
// - Missing indirectly addressed operand word raises the fault.
`timescale 1ns/1ns
`default_nettype none
`include "bwa_params.svh"

module bwa_alu
(
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  input  wire logic                ce,
  input  wire logic                op_valid,
  input  wire bwa_pkg::bwa_req_t   op_req,
  input  wire logic [`BWA_AW-1:0]  reg_addr,
  input  wire logic [`BWA_W-1:0]   reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [`BWA_W-1:0]        reg_rdata,
  output logic [`BWA_W-1:0]        result_lo,
  output logic [`BWA_W-1:0]        result_hi,
  output logic                     result_lo_wr,
  output logic                     result_hi_wr,
  output logic                     op_done,
  output bwa_pkg::bwa_flags_t      flags
);

  logic                   en_reg;
  logic [`BWA_W-1:0]      lo_reg;
  logic [`BWA_W-1:0]      hi_reg;
  logic                   lo_wr_reg;
  logic                   hi_wr_reg;
  logic                   done_reg;
  logic                   cy_reg;
  logic                   zr_reg;
  logic                   ft_reg;
  logic [`BWA_W-1:0]      rdata_reg;

  logic                   take;
  logic                   exec;
  logic [`BWA_W:0]        diff;
  logic [2*`BWA_W-1:0]    prod;
  logic [`BWA_W-1:0]      quot;
  logic [`BWA_W-1:0]      rem;
  logic [`BWA_W-1:0]      lo_next;
  logic [`BWA_W-1:0]      hi_next;
  logic                   lo_wr_next;
  logic                   hi_wr_next;
  logic                   cy_next;
  logic                   zr_next;
  logic                   ft_next;
  logic                   set_fault;
  logic                   sw_flag_wr;

  // An instruction is taken only while the unit is enabled
  assign take = ce & op_valid & en_reg;
  // Not executed when the condition is off
  assign exec = take & op_req.exec_cond;
  assign sw_flag_wr = ce & reg_wr & (reg_addr == `BWA_ADDR_FLAGS);

  // Borrow comes out as bit 16 of the widened difference
  assign diff = {1'b0, op_req.operand_a} - {1'b0, op_req.operand_b}
                - {{`BWA_W{1'b0}}, cy_reg};
  assign prod = {`BWA_WORD_ZERO, op_req.operand_a}
                * {`BWA_WORD_ZERO, op_req.operand_b};
  // Guard keeps the divider defined when the denominator is zero
  assign quot = (op_req.operand_b == `BWA_WORD_ZERO) ? `BWA_WORD_ZERO
                : op_req.operand_a / op_req.operand_b;
  assign rem  = (op_req.operand_b == `BWA_WORD_ZERO) ? `BWA_WORD_ZERO
                : op_req.operand_a % op_req.operand_b;

  // Result and flag next values for the executed instruction
  always_comb
  begin
    lo_next    = lo_reg;
    hi_next    = hi_reg;
    lo_wr_next = 1'b0;
    hi_wr_next = 1'b0;
    cy_next    = cy_reg;
    zr_next    = zr_reg;
    set_fault  = 1'b0;
    if (exec)
    begin
      if (op_req.operand_fault)
      begin
        set_fault = 1'b1;
      end
      else
      begin
        case (op_req.op)
          bwa_pkg::bwa_binary_subtract_op:
          begin
            lo_next    = diff[`BWA_W-1:0];
            lo_wr_next = 1'b1;
            cy_next    = diff[`BWA_W];
            zr_next    = (diff[`BWA_W-1:0] == `BWA_WORD_ZERO);
          end
          bwa_pkg::bwa_binary_multiply_op:
          begin
            lo_next    = prod[`BWA_W-1:0];
            hi_next    = prod[2*`BWA_W-1:`BWA_W];
            lo_wr_next = 1'b1;
            hi_wr_next = 1'b1;
            zr_next    = (prod == `BWA_DWORD_ZERO);
          end
          bwa_pkg::bwa_binary_divide_op:
          begin
            if (op_req.operand_b == `BWA_WORD_ZERO)
            begin
              set_fault = 1'b1;
            end
            else
            begin
              lo_next    = quot;
              hi_next    = rem;
              lo_wr_next = 1'b1;
              hi_wr_next = 1'b1;
              zr_next    = (quot == `BWA_WORD_ZERO);
            end
          end
          bwa_pkg::bwa_bitwise_conjunction_op:
          begin
            lo_next    = op_req.operand_a & op_req.operand_b;
            lo_wr_next = 1'b1;
            zr_next    = ((op_req.operand_a & op_req.operand_b)
                          == `BWA_WORD_ZERO);
          end
          bwa_pkg::bwa_carry_clear_op:
          begin
            cy_next = 1'b0;
          end
          default:
          begin
            lo_next = lo_reg;
          end
        endcase
      end
    end
    else if (sw_flag_wr)
    begin
      // Software may preset the carry; an executed instruction wins
      cy_next = reg_wdata[`BWA_FLG_CY_BIT];
    end
  end

  // Fault is sticky until software writes one to it; a new set wins
  always_comb
  begin
    ft_next = ft_reg;
    if (sw_flag_wr & reg_wdata[`BWA_FLG_FT_BIT])
    begin
      ft_next = 1'b0;
    end
    if (set_fault)
    begin
      ft_next = 1'b1;
    end
  end

  // Result words and write pulses
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lo_reg    <= `BWA_WORD_ZERO;
      hi_reg    <= `BWA_WORD_ZERO;
      lo_wr_reg <= 1'b0;
      hi_wr_reg <= 1'b0;
      done_reg  <= 1'b0;
    end
    else if (ce)
    begin
      lo_reg    <= lo_next;
      hi_reg    <= hi_next;
      lo_wr_reg <= lo_wr_next;
      hi_wr_reg <= hi_wr_next;
      done_reg  <= take;
    end
  end

  // Flags
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cy_reg <= 1'b0;
      zr_reg <= 1'b0;
      ft_reg <= 1'b0;
    end
    else if (ce)
    begin
      cy_reg <= cy_next;
      zr_reg <= zr_next;
      ft_reg <= ft_next;
    end
  end

  // Control register: unit enable
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_reg <= `BWA_CTRL_RST;
    end
    else if (ce & reg_wr & (reg_addr == `BWA_ADDR_CTRL))
    begin
      en_reg <= reg_wdata[`BWA_CTRL_EN_BIT];
    end
  end

  // Read data, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_reg <= `BWA_WORD_ZERO;
    end
    else if (ce)
    begin
      rdata_reg <= `BWA_WORD_ZERO;
      if (reg_rd)
      begin
        case (reg_addr)
          `BWA_ADDR_CTRL:   rdata_reg[`BWA_CTRL_EN_BIT] <= en_reg;
          `BWA_ADDR_FLAGS:
          begin
            rdata_reg[`BWA_FLG_CY_BIT] <= cy_reg;
            rdata_reg[`BWA_FLG_ZR_BIT] <= zr_reg;
            rdata_reg[`BWA_FLG_FT_BIT] <= ft_reg;
          end
          `BWA_ADDR_RES_LO: rdata_reg <= lo_reg;
          `BWA_ADDR_RES_HI: rdata_reg <= hi_reg;
          default:          rdata_reg <= `BWA_WORD_ZERO;
        endcase
      end
    end
  end

  assign reg_rdata              = rdata_reg;
  assign result_lo              = lo_reg;
  assign result_hi              = hi_reg;
  assign result_lo_wr           = lo_wr_reg;
  assign result_hi_wr           = hi_wr_reg;
  assign op_done                = done_reg;
  // One driver for the whole flag group: fault, zero, carry from the top
  assign flags                  = {ft_reg, zr_reg, cy_reg};

  // Checking aid: instruction and pre-op state of the previous clock cycle
  logic                 h_exec;
  logic                 h_take;
  logic                 h_cy;
  logic                 h_zr;
  logic [`BWA_W-1:0]    h_lo;
  bwa_pkg::bwa_req_t    h_req;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      h_exec <= 1'b0;
      h_take <= 1'b0;
      h_cy   <= 1'b0;
      h_zr   <= 1'b0;
      h_lo   <= `BWA_WORD_ZERO;
      h_req  <= '0;
    end
    else
    begin
      h_exec <= exec;
      h_take <= take;
      h_cy   <= cy_reg;
      h_zr   <= zr_reg;
      h_lo   <= lo_reg;
      h_req  <= op_req;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_skip_holds: assert property (
    h_take && !h_exec |-> !lo_wr_reg && lo_reg == h_lo && zr_reg == h_zr)
    else $error("result changed with condition off");

  chk_sub_word: assert property (
    h_exec && !h_req.operand_fault
    && h_req.op == bwa_pkg::bwa_binary_subtract_op
    |-> lo_reg == h_req.operand_a - h_req.operand_b
                  - {{(`BWA_W-1){1'b0}}, h_cy})
    else $error("subtract result wrong");

  chk_sub_borrow: assert property (
    h_exec && !h_req.operand_fault
    && h_req.op == bwa_pkg::bwa_binary_subtract_op
    |-> cy_reg == ({1'b0, h_req.operand_a}
                   < {1'b0, h_req.operand_b} + {{`BWA_W{1'b0}}, h_cy}))
    else $error("carry after subtract wrong");

  chk_mul_words: assert property (
    h_exec && !h_req.operand_fault
    && h_req.op == bwa_pkg::bwa_binary_multiply_op
    |-> {hi_reg, lo_reg} == {`BWA_WORD_ZERO, h_req.operand_a}
                            * {`BWA_WORD_ZERO, h_req.operand_b}
        && hi_wr_reg)
    else $error("product words wrong");

  chk_div_zero: assert property (
    take && op_req.exec_cond && op_req.op == bwa_pkg::bwa_binary_divide_op
    && op_req.operand_b == `BWA_WORD_ZERO
    |=> ft_reg && !lo_wr_reg && $stable(lo_reg) && $stable(hi_reg))
    else $error("divide by zero not faulted");

  chk_div_words: assert property (
    h_exec && !h_req.operand_fault
    && h_req.op == bwa_pkg::bwa_binary_divide_op
    && h_req.operand_b != `BWA_WORD_ZERO
    |-> {`BWA_WORD_ZERO, lo_reg} * {`BWA_WORD_ZERO, h_req.operand_b}
        + {`BWA_WORD_ZERO, hi_reg} == {`BWA_WORD_ZERO, h_req.operand_a}
        && hi_reg < h_req.operand_b)
    else $error("quotient or remainder wrong");

  chk_and_word: assert property (
    h_exec && !h_req.operand_fault
    && h_req.op == bwa_pkg::bwa_bitwise_conjunction_op
    |-> lo_reg == (h_req.operand_a & h_req.operand_b) && !hi_wr_reg)
    else $error("AND result wrong");

  chk_zero_flag: assert property (
    lo_wr_reg && !hi_wr_reg |-> zr_reg == (lo_reg == `BWA_WORD_ZERO))
    else $error("zero flag disagrees with result");

  chk_bad_operand: assert property (
    exec && op_req.operand_fault |=> ft_reg && !lo_wr_reg && !hi_wr_reg)
    else $error("missing operand not faulted");

  chk_carry_clear: assert property (
    exec && !op_req.operand_fault
    && op_req.op == bwa_pkg::bwa_carry_clear_op |=> !cy_reg)
    else $error("carry not cleared");

endmodule
`default_nettype wire

// [verif/bwa_alu_tb.sv]
/*
  Self-checking bench for the binary word arithmetic and logic unit:
  directed corner cases, a borrow chain and seeded random instructions.
  Assumes the unit's own assertions guard its timing internally.
*/
`timescale 1ns/1ns
`default_nettype none
`include "bwa_params.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end

module bwa_alu_tb;
  logic                sys_clk;
  logic                rst_n;
  logic                ce;
  logic                op_valid;
  bwa_pkg::bwa_req_t   op_req;
  bwa_pkg::bwa_req_t   q;
  logic [3:0]          reg_addr;
  logic [15:0]         reg_wdata;
  logic                reg_wr;
  logic                reg_rd;
  logic [15:0]         reg_rdata;
  logic [15:0]         result_lo;
  logic [15:0]         result_hi;
  logic                result_lo_wr;
  logic                result_hi_wr;
  logic                op_done;
  bwa_pkg::bwa_flags_t flags;
  int                  n_fail;
  int                  checks;
  int                  cycles;
  int                  seed;
  int                  i;
  logic [31:0]         r;
  logic                m_cy;
  logic                m_zr;
  logic                m_ft;
  logic                e_lw;
  logic                e_hw;
  logic [15:0]         m_lo;
  logic [15:0]         m_hi;
  bwa_pkg::bwa_op_t    ops [5];

  bwa_alu i_bwa_alu (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
    .op_valid(op_valid), .op_req(op_req), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .result_lo(result_lo), .result_hi(result_hi),
    .result_lo_wr(result_lo_wr), .result_hi_wr(result_hi_wr),
    .op_done(op_done), .flags(flags));

  // Free-running 100 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Hang guard, far above the several hundred cycles the run needs
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    begin
      if (n_fail == 0 && checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  function automatic bwa_pkg::bwa_req_t mk(input bwa_pkg::bwa_op_t o,
    input logic [15:0] a, input logic [15:0] b, input logic ex,
    input logic ft);
    mk = {o, ex, ft, a, b};
  endfunction

  // Reference behaviour; fault is sticky and blocks the result
  task automatic predict(input bwa_pkg::bwa_req_t x, input logic tk);
    logic [16:0] d;
    logic [31:0] p;
    begin
      e_lw = 1'b0;
      e_hw = 1'b0;
      if (tk && x.exec_cond && x.operand_fault)
        m_ft = 1'b1;
      else if (tk && x.exec_cond)
        case (x.op)
          bwa_pkg::bwa_binary_subtract_op:
          begin
            d = {1'b0, x.operand_a} - {1'b0, x.operand_b} - m_cy;
            m_lo = d[15:0];
            m_cy = d[16];
            m_zr = (d[15:0] == 16'h0000);
            e_lw = 1'b1;
          end
          bwa_pkg::bwa_binary_multiply_op:
          begin
            p = x.operand_a * x.operand_b;
            {m_hi, m_lo} = p;
            m_zr = (p == 32'h0000_0000);
            e_lw = 1'b1;
            e_hw = 1'b1;
          end
          bwa_pkg::bwa_binary_divide_op:
            if (x.operand_b == 16'h0000)
              m_ft = 1'b1;
            else
            begin
              m_lo = x.operand_a / x.operand_b;
              m_hi = x.operand_a % x.operand_b;
              m_zr = (m_lo == 16'h0000);
              e_lw = 1'b1;
              e_hw = 1'b1;
            end
          bwa_pkg::bwa_bitwise_conjunction_op:
          begin
            m_lo = x.operand_a & x.operand_b;
            m_zr = (m_lo == 16'h0000);
            e_lw = 1'b1;
          end
          bwa_pkg::bwa_carry_clear_op:
            m_cy = 1'b0;
          default:
            e_lw = 1'b0; // Unknown code writes nothing
        endcase
    end
  endtask

  // One instruction, then every result and flag output checked in the answer cycle
  task automatic issue(input bwa_pkg::bwa_req_t x, input logic tk);
    begin
      @(posedge sys_clk);
      op_valid <= 1'b1;
      op_req <= x;
      @(posedge sys_clk);
      op_valid <= 1'b0;
      predict(x, tk);
      #1;
      `CHK("op_done", tk, op_done)
      `CHK("result_lo_wr", e_lw, result_lo_wr)
      `CHK("result_hi_wr", e_hw, result_hi_wr)
      `CHK("result_lo", m_lo, result_lo)
      `CHK("result_hi", m_hi, result_hi)
      `CHK("flags", {m_ft, m_zr, m_cy}, flags)
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    begin
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      if (a == `BWA_ADDR_FLAGS)
      begin
        m_cy = d[0];
        if (d[2])
          m_ft = 1'b0;
      end
    end
  endtask

  task automatic reg_read(input logic [3:0] a, input logic [15:0] e);
    begin
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      `CHK("reg_rdata", e, reg_rdata)
    end
  endtask

  // Main sequence: reset, corners, then seeded random traffic
  initial
  begin
    {ce, op_valid, reg_wr, reg_rd, op_req, reg_addr, reg_wdata} = '0;
    {m_cy, m_zr, m_ft, m_lo, m_hi, n_fail, checks, cycles} = '0;
    rst_n = 1'b0;
    seed = 32'hfe25;
    ops = '{bwa_pkg::bwa_binary_subtract_op, bwa_pkg::bwa_binary_multiply_op,
      bwa_pkg::bwa_binary_divide_op, bwa_pkg::bwa_bitwise_conjunction_op,
      bwa_pkg::bwa_carry_clear_op};
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    ce <= 1'b1;
    reg_read(`BWA_ADDR_CTRL, 16'h0001);
    reg_write(4'h7, 16'hffff);
    reg_read(4'h7, 16'h0000);
    // Two-word borrow chain
    issue(mk(ops[4], 16'h0000, 16'h0000, 1'b1, 1'b0), 1'b1);
    issue(mk(ops[0], 16'h5a10, 16'h60e3, 1'b1, 1'b0), 1'b1);
    issue(mk(ops[0], 16'h20f5, 16'hb8a3, 1'b1, 1'b0), 1'b1);
    `CHK("chain_hi_word", 16'h6851, result_lo)
    reg_read(`BWA_ADDR_RES_LO, m_lo);
    reg_read(`BWA_ADDR_FLAGS, {13'h0000, m_ft, m_zr, m_cy});
    issue(mk(ops[1], 16'hffff, 16'hffff, 1'b1, 1'b0), 1'b1);
    reg_read(`BWA_ADDR_RES_HI, m_hi);
    issue(mk(ops[3], 16'ha5a5, 16'h5a5a, 1'b1, 1'b0), 1'b1);
    issue(mk(ops[0], 16'h1234, 16'h0001, 1'b0, 1'b0), 1'b1);
    issue(mk(ops[2], 16'h1234, 16'h0000, 1'b1, 1'b0), 1'b1);
    reg_write(`BWA_ADDR_FLAGS, 16'h0005);
    issue(mk(ops[3], 16'hffff, 16'hffff, 1'b1, 1'b1), 1'b1);
    reg_write(`BWA_ADDR_FLAGS, 16'h0005);
    issue(mk(ops[0], 16'h0000, 16'h0000, 1'b1, 1'b0), 1'b1);
    issue(mk(ops[2], 16'h0007, 16'h0003, 1'b1, 1'b0), 1'b1);
    // Undefined operation code: only the done pulse, nothing else moves
    q = mk(bwa_pkg::bwa_op_t'(5'h03), 16'h0001, 16'h0001, 1'b1, 1'b0);
    issue(q, 1'b1);
    // Frozen clock enable and disabled unit both ignore the request
    @(posedge sys_clk);
    ce <= 1'b0;
    issue(mk(ops[4], 16'h0000, 16'h0000, 1'b1, 1'b0), 1'b0);
    @(posedge sys_clk);
    ce <= 1'b1;
    reg_write(`BWA_ADDR_CTRL, 16'h0000);
    issue(mk(ops[1], 16'h0003, 16'h0005, 1'b1, 1'b0), 1'b0);
    reg_write(`BWA_ADDR_CTRL, 16'h0001);
    // Mid-run reset clears every output; the unit comes back enabled
    @(posedge sys_clk);
    rst_n <= 1'b0;
    @(posedge sys_clk);
    #1;
    `CHK("rst_words", 48'h0, {reg_rdata, result_lo, result_hi})
    `CHK("rst_wr", 2'h0, {result_lo_wr, result_hi_wr})
    `CHK("rst_done", 1'b0, op_done)
    `CHK("rst_flags", 3'h0, flags)
    {m_cy, m_zr, m_ft, m_lo, m_hi} = '0;
    @(posedge sys_clk);
    rst_n <= 1'b1;
    for (i = 0; i < 300; i++)
    begin
      r = $random(seed);
      q = mk(ops[r[7:0] % 5], 16'($random(seed)), 16'($random(seed)),
        r[10:8] != 3'h0, r[14:11] == 4'h0);
      if (r[19:16] == 4'h0)
        q.operand_b = 16'h0000;
      issue(q, 1'b1);
      if (m_ft)
        reg_write(`BWA_ADDR_FLAGS, {15'h0000, r[20]} | 16'h0004);
    end
    give_verdict();
  end
endmodule

`default_nettype wire
